// ---- rtl/parity_dram_card_map.vh ----
// Constants for the parity DRAM card control logic.
// Function
// RULE1 - One byte-wide control and status I/O port.
// RULE2 - Stored parity is one for even ones.
// RULE3 - Port write with bit 4 clear disables generation.
// RULE4 - Even check on read sets error flag.
// RULE5 - Master clears flag writing 01 then 11.
// RULE6 - Generator and flag disabled after reset.
// RULE7 - Writing bits 4 and 5 set enables both.
// RULE8 - Port read bit 0 shows error flag.
// RULE9 - Row bits during row strobe, then column bits.
// RULE10 - Refresh drives eight-bit refresh row address.
// RULE11 - Refresh timer requests refresh periodically, independently.
// RULE12 - Refresh request synchronised through flip-flops first.
// RULE13 - Refresh and access contention is arbitrated.
// RULE14 - Four banks of eight 64K x 1 devices.
// RULE15 - Populations of four, two or one bank.
// RULE16 - Two 9-bit parity generator checkers, one per bus.
// RULE17 - Checker combines stored parity with read byte.
// RULE18 - Output lines drive either bank bus on writes.
// RULE19 - 16-bit read couples even bus onto output lines.
// RULE20 - Even or odd bus couples onto input lines.
// RULE21 - 16-bit write couples input lines to odd bus.
// RULE22 - Port decodes where address switch matches A0-A7.
// RULE23 - Width chosen by 16REQ/16ACK handshake.
// RULE24 - Access during refresh waits until both done.
`ifndef PARITY_DRAM_CARD_MAP_VH
`define PARITY_DRAM_CARD_MAP_VH
`define GEN_EN_BIT      4
`define FLAG_EN_BIT     5
`define ERR_STATUS_BIT  0
`define REFRESH_US      15
`define REFRESH_CYCLES  ((`REFRESH_US * 50) - 1)
`define ROW_CYCLES      3'h2
`define COL_CYCLES      3'h3
`define REF_CYCLES      3'h4
`define POP_256K        2'h0
`define POP_128K        2'h1
`define POP_64K         2'h3
`endif

// ---- rtl/parity_checker9.v ----
// Nine-bit parity generator and checker for one bank data bus.
`timescale 1ns/10ps
`include "parity_dram_card_map.vh"
module parity_checker9 (
  // Data and stored parity.
  input  wire [7:0] data,
  input  wire       storedParity,
  // Results.
  output wire       genParity,
  output wire       checkEven
);
  assign genParity = ~(^data); // [RULE2] [RULE16]
  assign checkEven = ~(^{data, storedParity}); // [RULE17]
endmodule // parity_checker9

// ---- rtl/parity_dram_card_control.v ----
// Control logic of the parity DRAM expansion card.
`timescale 1ns/10ps
`include "parity_dram_card_map.vh"
module parity_dram_card_control (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst,
  // Bus cycle.
  input  wire [23:0] busAddr,
  input  wire        boardSel,
  input  wire        memRead,
  input  wire        memWrite,
  input  wire        ioRead,
  input  wire        ioWrite,
  input  wire        req16,
  input  wire [7:0]  busDataOut,
  output reg  [7:0]  busDataIn,
  output reg  [7:0]  busDataOutDrv,
  output wire        busDataOutOe,
  output wire        ack16,
  output wire        busReady,
  // Configuration straps.
  input  wire [7:0]  port_address_switch,
  input  wire [1:0]  population,
  // DRAM array.
  output reg  [7:0]  dramAddr,
  output reg  [3:0]  rowStrobe,
  output reg  [3:0]  colStrobe,
  output reg         dramWe,
  output reg  [7:0]  evenBusOut,
  output reg  [7:0]  oddBusOut,
  output reg         evenParityOut,
  output reg         oddParityOut,
  input  wire [7:0]  evenBusIn,
  input  wire [7:0]  oddBusIn,
  input  wire        evenParityIn,
  input  wire        oddParityIn
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ROW  = 3'h1;
  localparam ST_COL  = 3'h2;
  localparam ST_DONE = 3'h3;
  localparam ST_REF  = 3'h4;

  reg  [2:0]  state_r;
  reg  [9:0]  timer_r;
  reg         refTick_r;
  reg         refSync1_r;
  reg         refSync2_r;
  reg         refSync3_r;
  reg         refPend_r;
  reg  [7:0]  refAddr_r;
  reg  [2:0]  cnt_r;
  reg         genEn_r;
  reg         flagEn_r;
  reg         errFlag_r;
  reg         clearArmed_r;
  reg         wide_r;
  reg         isWrite_r;
  reg  [3:0]  bankMask_r;
  reg  [15:0] addr_r;
  reg         lowBit_r;
  wire        portHit;
  wire        access;
  wire        refEdge;
  wire        genEven;
  wire        genOdd;
  wire        chkEven;
  wire        chkOdd;
  wire        wideOk;
  wire        bankHigh;
  wire        oddByte;
  wire        errEvent;

  assign portHit = (busAddr[7:0] == port_address_switch); // [RULE22]
  assign access = boardSel & (memRead | memWrite);
  assign wideOk = (population != `POP_64K); // [RULE15]
  assign ack16 = req16 & wideOk & access; // [RULE23]
  assign oddByte = (population == `POP_64K) ? 1'b0 : lowBit_r;
  assign bankHigh = (population == `POP_256K) ? busAddr[17] : 1'b0; // [RULE14] [RULE15]
  assign busReady = ~access | (state_r == ST_DONE); // [RULE24]
  assign busDataOutOe = wide_r & ~isWrite_r & (state_r == ST_DONE); // [RULE19]
  assign refEdge = refSync2_r & ~refSync3_r;

  parity_checker9 evenChk (
    .data         (isWrite_r ? evenBusOut : evenBusIn),
    .storedParity (evenParityIn),
    .genParity    (genEven),
    .checkEven    (chkEven)
  );
  parity_checker9 oddChk (
    .data         (isWrite_r ? oddBusOut : oddBusIn),
    .storedParity (oddParityIn),
    .genParity    (genOdd),
    .checkEven    (chkOdd)
  );

  assign errEvent = flagEn_r & ~isWrite_r & (state_r == ST_COL) & (cnt_r == 3'h0) &
                    ((bankMask_r[0] | bankMask_r[2]) & chkEven | (bankMask_r[1] | bankMask_r[3]) & chkOdd); // [RULE4]

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_r <= 10'h000;
      refTick_r <= 1'b0;
    end else begin
      if (timer_r == `REFRESH_CYCLES) begin // [RULE11]
        timer_r <= 10'h000;
        refTick_r <= 1'b1;
      end else begin
        timer_r <= timer_r + 10'h001;
        refTick_r <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      refSync1_r <= 1'b0;
      refSync2_r <= 1'b0;
      refSync3_r <= 1'b0;
    end else begin
      refSync1_r <= refTick_r; // [RULE12]
      refSync2_r <= refSync1_r;
      refSync3_r <= refSync2_r;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      genEn_r <= 1'b0; // [RULE6]
      flagEn_r <= 1'b0;
      errFlag_r <= 1'b0;
      clearArmed_r <= 1'b0;
      busDataIn <= 8'h00;
    end else begin
      if (ioWrite & portHit) begin // [RULE1]
        genEn_r <= busDataOut[`GEN_EN_BIT]; // [RULE3] [RULE7]
        flagEn_r <= busDataOut[`GEN_EN_BIT] & busDataOut[`FLAG_EN_BIT];
        clearArmed_r <= busDataOut[`GEN_EN_BIT] & ~busDataOut[`FLAG_EN_BIT];
      end
      if (errEvent) begin
        errFlag_r <= 1'b1;
      end else if (ioWrite & portHit & clearArmed_r & busDataOut[`GEN_EN_BIT] & busDataOut[`FLAG_EN_BIT]) begin
        errFlag_r <= 1'b0; // [RULE5]
      end
      if (ioRead & portHit) begin
        busDataIn <= {7'h00, errFlag_r}; // [RULE8]
      end else if (~isWrite_r & (state_r == ST_COL) & (cnt_r == 3'h0)) begin
        busDataIn <= (oddByte & ~wide_r) ? oddBusIn : evenBusIn; // [RULE20]
        if (wide_r) begin
          busDataIn <= oddBusIn;
        end
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      refPend_r <= 1'b0;
      refAddr_r <= 8'h00;
      wide_r <= 1'b0;
      isWrite_r <= 1'b0;
      bankMask_r <= 4'h0;
      addr_r <= 16'h0000;
      lowBit_r <= 1'b0;
      dramAddr <= 8'h00;
      rowStrobe <= 4'h0;
      colStrobe <= 4'h0;
      dramWe <= 1'b0;
      evenBusOut <= 8'h00;
      oddBusOut <= 8'h00;
      evenParityOut <= 1'b0;
      oddParityOut <= 1'b0;
      busDataOutDrv <= 8'h00;
    end else begin
      if (refEdge) begin
        refPend_r <= 1'b1;
      end
      case (state_r)
        ST_IDLE: begin
          rowStrobe <= 4'h0;
          colStrobe <= 4'h0;
          dramWe <= 1'b0;
          if (refPend_r | refEdge) begin // [RULE13]
            refPend_r <= 1'b0;
            dramAddr <= refAddr_r; // [RULE10]
            rowStrobe <= 4'hf;
            cnt_r <= `REF_CYCLES;
            state_r <= ST_REF;
          end else if (access) begin
            addr_r <= busAddr[16:1];
            lowBit_r <= busAddr[0];
            wide_r <= ack16;
            isWrite_r <= memWrite;
            dramAddr <= busAddr[8:1]; // [RULE9]
            if (ack16) begin
              bankMask_r <= bankHigh ? 4'hc : 4'h3;
            end else if (population == `POP_64K) begin
              bankMask_r <= 4'h1;
            end else begin
              bankMask_r <= {bankHigh & busAddr[0], bankHigh & ~busAddr[0],
                             ~bankHigh & busAddr[0], ~bankHigh & ~busAddr[0]};
            end
            evenBusOut <= busDataOut; // [RULE18]
            oddBusOut <= (ack16 | ~busAddr[0]) ? busDataIn : busDataOut;
            if (ack16) begin
              oddBusOut <= busDataIn; // [RULE21]
            end else begin
              oddBusOut <= busDataOut;
            end
            cnt_r <= `ROW_CYCLES;
            state_r <= ST_ROW;
          end
        end
        ST_ROW: begin
          rowStrobe <= bankMask_r;
          if (cnt_r == 3'h0) begin
            dramAddr <= (population == `POP_64K) ? {lowBit_r, addr_r[14:8]} : addr_r[15:8]; // [RULE9]
            evenParityOut <= genEn_r & genEven; // [RULE2]
            oddParityOut <= genEn_r & genOdd;
            dramWe <= isWrite_r;
            cnt_r <= `COL_CYCLES;
            state_r <= ST_COL;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        ST_COL: begin
          colStrobe <= bankMask_r;
          if (cnt_r == 3'h0) begin
            busDataOutDrv <= evenBusIn; // [RULE19]
            state_r <= ST_DONE;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        ST_DONE: begin
          rowStrobe <= 4'h0;
          colStrobe <= 4'h0;
          dramWe <= 1'b0;
          if (~access) begin
            state_r <= ST_IDLE;
          end
        end
        ST_REF: begin
          if (cnt_r == 3'h0) begin
            rowStrobe <= 4'h0;
            refAddr_r <= refAddr_r + 8'h01;
            state_r <= ST_IDLE; // [RULE24]
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // parity_dram_card_control

// ---- verification/card_checker_assertions.sv ----
// Assertions on the card control ports.
`timescale 1ns/10ps
module card_checker (
  // Watched ports.
  input wire        clk, rst, boardSel, memRead, memWrite, ioRead, ioWrite, req16, ack16, busReady,
  input wire [23:0] busAddr,
  input wire [7:0]  busDataIn, busDataOut, port_address_switch,
  input wire [1:0]  population,
  input wire [3:0]  rowStrobe, colStrobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire       acc = boardSel && (memRead || memWrite);
  wire       hit = busAddr[7:0] == port_address_switch;
  reg        on_r;
  reg  [9:0] gap_r;
  always @(posedge clk or posedge rst)
    if (rst) begin
      on_r <= 1'b0;
      gap_r <= 10'h0;
    end else begin
      if (ioWrite && hit && busDataOut[5:4] == 2'h3)
        on_r <= 1'b1;
      gap_r <= (rowStrobe == 4'hf) ? 10'h0 : gap_r + 10'h1;
    end
  sequence portRd; ioRead && hit; endsequence
  sequence accGo; $rose(acc); endsequence
  ack_width_a: assert property (ack16 == (req16 && acc && population != 2'h3)) else $error("ack16 wrong");
  idle_ready_a: assert property (!acc |-> busReady) else $error("ready low when idle");
  access_wait_a: assert property (accGo |-> !busReady) else $error("no wait at access start");
  ready_bound_a: assert property (accGo |-> ##[1:30] busReady) else $error("access never ends");
  port_read_a: assert property (portRd |=> ##1 busDataIn[7:1] == 7'h0) else $error("port high bits set");
  flag_off_a: assert property (ioRead && hit && !on_r |=> ##1 !busDataIn[0]) else $error("flag while off");
  ras_cas_a: assert property (|colStrobe |-> (colStrobe & ~rowStrobe) == 4'h0) else $error("column without row");
  refresh_rows_a: assert property (rowStrobe == 4'hf |-> colStrobe == 4'h0) else $error("column in refresh");
  refresh_period_a: assert property (gap_r < 10'h384) else $error("refresh overdue");
  small_array_a: assert property (population == 2'h3 && |colStrobe |-> colStrobe == 4'h1) else $error("bank");
endmodule // card_checker
bind parity_dram_card_control card_checker checks (.clk, .rst, .boardSel, .memRead, .memWrite, .ioRead, .ioWrite,
  .req16, .ack16, .busReady, .busAddr, .busDataIn, .busDataOut, .port_address_switch, .population, .rowStrobe,
  .colStrobe);

// ---- verification/dram_array_model.sv ----
// Behavioural DRAM array with one parity bit per byte.
`timescale 1ns/10ps
module dram_array_model (
  // Strobes, address and data.
  input wire       clk, dramWe, evenParityOut, oddParityOut, flipParity,
  input wire [7:0] dramAddr, evenBusOut, oddBusOut,
  input wire [3:0] rowStrobe, colStrobe,
  output wire [7:0] evenBusIn, oddBusIn,
  output wire      evenParityIn, oddParityIn
);
  reg [8:0] mem [0:262143];
  reg [7:0] row [0:3];
  reg [8:0] rdE = 9'h0, rdO = 9'h0;
  reg [3:0] rasQ = 4'h0, casQ = 4'h0;
  integer   b, k;
  // Four banks keyed by bank, row and column.
  always @(posedge clk) begin
    for (b = 0; b < 4; b = b + 1) begin
      if (rowStrobe[b] && !rasQ[b])
        row[b] = dramAddr;
      k = {b[1:0], row[b], dramAddr};
      if (colStrobe[b] && !casQ[b]) begin
        if (dramWe)
          mem[k] = b[0] ? {oddParityOut, oddBusOut} : {evenParityOut, evenBusOut};
        else if (b[0])
          rdO = mem[k] ^ {flipParity, 8'h0};
        else
          rdE = mem[k] ^ {flipParity, 8'h0};
      end
    end
    rasQ = rowStrobe;
    casQ = colStrobe;
  end
  // Released buses show the inverse of the last value.
  assign {evenParityIn, evenBusIn} = (colStrobe[0] | colStrobe[2]) ? rdE : ~rdE;
  assign {oddParityIn, oddBusIn} = (colStrobe[1] | colStrobe[3]) ? rdO : ~rdO;
endmodule // dram_array_model

// ---- verification/tb.sv ----
// Self-checking bench for the card control logic.
`timescale 1ns/10ps
module tb;
  reg         clk = 1'b0, rst = 1'b1, boardSel = 1'b0, memRead = 1'b0, memWrite = 1'b0;
  reg         ioRead = 1'b0, ioWrite = 1'b0, req16 = 1'b0, flipParity = 1'b0, pe, oe, ak;
  reg  [23:0] busAddr = 24'h0;
  reg  [7:0]  busDataOut = 8'h0, rd, rdE;
  reg  [1:0]  population = 2'h0;
  wire [7:0]  busDataIn, busDataOutDrv, dramAddr, evenBusOut, oddBusOut, evenBusIn, oddBusIn;
  wire [3:0]  rowStrobe, colStrobe;
  wire        busDataOutOe, ack16, busReady, dramWe, evenParityOut, oddParityOut, evenParityIn, oddParityIn;
  wire [7:0]  port_address_switch = 8'ha5;
  integer     miscompares = 0, checked = 0, cyc = 0, i;
  parity_dram_card_control uut (.clk, .rst, .busAddr, .boardSel, .memRead, .memWrite, .ioRead, .ioWrite, .req16,
    .busDataOut, .busDataIn, .busDataOutDrv, .busDataOutOe, .ack16, .busReady, .port_address_switch, .population,
    .dramAddr, .rowStrobe, .colStrobe, .dramWe, .evenBusOut, .oddBusOut, .evenParityOut, .oddParityOut, .evenBusIn,
    .oddBusIn, .evenParityIn, .oddParityIn);
  dram_array_model mdl (.clk, .dramWe, .evenParityOut, .oddParityOut, .flipParity, .dramAddr, .evenBusOut,
    .oddBusOut, .rowStrobe, .colStrobe, .evenBusIn, .oddBusIn, .evenParityIn, .oddParityIn);
  always #10 clk = ~clk;
  task test_done;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      test_done;
    end
  end
  task chk(input [63:0] name, input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  // Port access: one-cycle strobe, status checked after it has settled.
  task io(input wr, input [7:0] a, input [7:0] d);
    begin
      busAddr = {16'h0, a};
      busDataOut = d;
      ioWrite = wr;
      ioRead = !wr;
      @(posedge clk) #1 ioWrite = 1'b0;
      ioRead = 1'b0;
      @(posedge clk) #1;
    end
  endtask
  task port(input [7:0] exp);
    begin
      io(1'b0, 8'ha5, 8'h0);
      chk("port", busDataIn, exp);
    end
  endtask
  // Memory cycle held until ready is seen, then dropped for one cycle.
  task mem(input wr, input [23:0] a, input [7:0] d, input w);
    integer n;
    begin
      busAddr = a;
      busDataOut = d;
      req16 = w;
      boardSel = 1'b1;
      memWrite = wr;
      memRead = !wr;
      n = 0;
      @(negedge clk);
      while (busReady !== 1'b1 && n < 50) begin
        @(negedge clk);
        n = n + 1;
      end
      rd = busDataIn;
      rdE = busDataOutDrv;
      pe = evenParityOut;
      oe = busDataOutOe;
      ak = ack16;
      @(posedge clk) #1 boardSel = 1'b0;
      memRead = 1'b0;
      memWrite = 1'b0;
      req16 = 1'b0;
      @(posedge clk) #1;
      if (n == 50)
        chk("ready", 8'h0, 8'h1);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    port(8'h00);
    mem(1'b1, 24'h0, 8'h03, 1'b0);
    io(1'b1, 8'ha6, 8'h30);
    flipParity = 1'b1;
    mem(1'b0, 24'h0, 8'h0, 1'b0);
    flipParity = 1'b0;
    port(8'h00);
    $display("reset test done");
    io(1'b1, 8'ha5, 8'h30);
    mem(1'b1, 24'h0, 8'h03, 1'b0);
    chk("parity", pe, 8'h1);
    mem(1'b1, 24'h2, 8'h07, 1'b0);
    chk("parity", pe, 8'h0);
    mem(1'b1, 24'h5, 8'h3c, 1'b0);
    mem(1'b1, 24'h4, 8'h5a, 1'b0);
    mem(1'b0, 24'h0, 8'h0, 1'b0);
    chk("data", rd, 8'h03);
    mem(1'b0, 24'h2, 8'h0, 1'b0);
    chk("data", rd, 8'h07);
    port(8'h00);
    flipParity = 1'b1;
    mem(1'b0, 24'h0, 8'h0, 1'b0);
    flipParity = 1'b0;
    port(8'h01);
    io(1'b1, 8'ha5, 8'h30);
    port(8'h01);
    io(1'b1, 8'ha5, 8'h10);
    io(1'b1, 8'ha5, 8'h30);
    port(8'h00);
    io(1'b1, 8'ha5, 8'h00);
    flipParity = 1'b1;
    mem(1'b0, 24'h0, 8'h0, 1'b0);
    flipParity = 1'b0;
    port(8'h00);
    $display("parity test done");
    mem(1'b0, 24'h4, 8'h0, 1'b1);
    chk("ack", ak, 8'h1);
    chk("even", rdE, 8'h5a);
    chk("oe", oe, 8'h1);
    chk("odd", rd, 8'h3c);
    population = 2'h3;
    mem(1'b0, 24'h4, 8'h0, 1'b1);
    chk("ack", ak, 8'h0);
    population = 2'h0;
    $display("width test done");
    for (i = 0; i < 90; i = i + 1) begin
      mem(1'b0, 24'h5, 8'h0, 1'b0);
      chk("soak", rd, 8'h3c);
    end
    $display("refresh test done");
    test_done;
  end
endmodule // tb
